// >>> hdl/slot_glue.sv
/*
 * expansion-slot glue: flash pass-through, internal registers,
 * interrupt latch, audio register and tone transceiver port.
 * assumes host strobes are asynchronous and active high after pin logic.
 */
// Function
// - first chip select routes access to flash
// - second chip select reaches internal registers
// - slot address picks flash word or register
// - write strobe latches slot data
// - read strobe drives selected data onto bus
// - slot reset drives flash reset and resets registers
// - interrupt line raised, cleared by host read
// - low battery blocks the interrupt line
// - flash receives the 24-bit address
// - flash data path carries flash traffic only
// - flash output enable during flash-space reads
// - flash write enable on flash-space writes
// - interrupt register read over 8-bit path
// - reading interrupt register clears all bits except events rising in the same cycle
// - audio write strobe captures audio data
// - audio shutdown output drives power-down
// - audio mute output silences speaker
// - tone read data captured while enabled
// - 8-bit tone register drives strobes and data
// - tone chip gets mode, select, chip strobes
// - audio mode output selects headphone path
// - audio register loads on strobe rising edge
// - shutdown follows bit 0, mute bit 1
`timescale 1ns/1ps
module slot_glue (
	input  wire logic                                 clk,            // 125 MHz clock
	input  wire logic                                 sys_rst,        // sync reset
	input  wire logic                                 slot_reset,     // host slot reset
	input  wire logic [slot_glue_pkg::ADDR_W-1:0]     slot_addr,      // slot address
	input  wire logic [slot_glue_pkg::DATA_W-1:0]     slot_data_in,   // slot data in
	output logic      [slot_glue_pkg::DATA_W-1:0]     slot_data_out,  // slot data out
	output logic                                      slot_data_oe,   // slot data drive
	input  wire logic                                 slot_sel_flash, // chip select 0
	input  wire logic                                 slot_sel_regs,  // chip select 1
	input  wire logic                                 slot_wr,        // write strobe
	input  wire logic                                 slot_rd,        // read strobe
	output logic                                      slot_irq,       // interrupt out
	input  wire logic                                 host_low_battery, // low battery
	output logic      [slot_glue_pkg::ADDR_W-1:0]     flash_addr,     // flash address
	input  wire logic [slot_glue_pkg::DATA_W-1:0]     flash_data_in,  // flash data in
	output logic      [slot_glue_pkg::DATA_W-1:0]     flash_data_out, // flash data out
	output logic                                      flash_data_oe,  // flash data drive
	output logic                                      flash_oe,       // flash read enable
	output logic                                      flash_we,       // flash write enable
	output logic                                      flash_reset,    // flash reset
	input  wire logic                                 ext_int,        // spare int source
	output logic                                      audio_shutdown, // audio power-down
	output logic                                      audio_mute,     // speaker mute
	output logic                                      audio_mode,     // headphone select
	input  wire logic [slot_glue_pkg::TONE_D_W-1:0]   tone_chip_data_in, // tone bus in
	output logic      [slot_glue_pkg::TONE_D_W-1:0]   tone_chip_data_out, // tone bus out
	output logic                                      tone_chip_data_oe, // tone bus drive
	output logic                                      tone_chip_write_mode, // write mode
	output logic                                      tone_chip_read_mode,  // read mode
	output logic                                      tone_chip_reg_select, // reg select
	output logic                                      tone_chip_select,     // chip select
	input  wire logic                                 tone_received_int     // tone irq
);
	logic                                 rst;
	logic                                 slot_reset_s;
	logic                                 sel_flash_s;
	logic                                 sel_regs_s;
	logic                                 wr_s;
	logic                                 rd_s;
	logic                                 tone_int_s;
	logic                                 ext_int_s;
	logic                                 wr_d_r;
	logic                                 rd_d_r;
	logic                                 wr_rise;
	logic                                 rd_rise;
	logic                                 flash_wr;
	logic                                 flash_rd;
	logic                                 hit_int;
	logic                                 hit_audio;
	logic                                 hit_tone;
	logic                                 audio_wr;
	logic                                 tone_wr;
	logic [slot_glue_pkg::TONE_D_W-1:0]   tone_data_s;
	slot_glue_pkg::slot_req_t             req;
	logic [slot_glue_pkg::INT_W-1:0]      int_src;
	logic [slot_glue_pkg::INT_W-1:0]      int_bits;
	logic                                 int_clear_on_read;
	logic [slot_glue_pkg::AUDIO_W-1:0]    audio_reg_bus;
	logic [slot_glue_pkg::AUDIO_W-1:0]    audio_r;
	logic [slot_glue_pkg::TONE_W-1:0]     tone_write_reg;
	logic [slot_glue_pkg::TONE_D_W-1:0]   tone_rd_r;
	logic                                 tone_rd_en;
	logic [slot_glue_pkg::DATA_W-1:0]     reg_rd_nxt;
	logic [slot_glue_pkg::DATA_W-1:0]     flash_rd_r;
	slot_glue_pkg::tone_ctl_t             tone_ctl;

	function automatic logic reg_hit(input logic [slot_glue_pkg::ADDR_W-1:0] a,
		input logic [1:0] idx);
		reg_hit = (a[1:0] == idx);
	endfunction : reg_hit

	// asynchronous slot controls pass through the pin filter
	pin_sync u_sync_rst (.clk(clk), .sys_rst(sys_rst), .pin_in(slot_reset),
		.level(slot_reset_s));
	pin_sync u_sync_cs0 (.clk(clk), .sys_rst(sys_rst), .pin_in(slot_sel_flash),
		.level(sel_flash_s));
	pin_sync u_sync_cs1 (.clk(clk), .sys_rst(sys_rst), .pin_in(slot_sel_regs),
		.level(sel_regs_s));
	pin_sync u_sync_wr (.clk(clk), .sys_rst(sys_rst), .pin_in(slot_wr),
		.level(wr_s));
	pin_sync u_sync_rd (.clk(clk), .sys_rst(sys_rst), .pin_in(slot_rd),
		.level(rd_s));
	pin_sync u_sync_tone (.clk(clk), .sys_rst(sys_rst), .pin_in(tone_received_int),
		.level(tone_int_s));
	pin_sync u_sync_ext (.clk(clk), .sys_rst(sys_rst), .pin_in(ext_int),
		.level(ext_int_s));

	// tone bus comes from another chip, so each bit is filtered too
	generate
		for (genvar i = 0; i < slot_glue_pkg::TONE_D_W; i++)
		begin : g_tone_sync
			pin_sync u_sync_tone_d (.clk(clk), .sys_rst(sys_rst),
				.pin_in(tone_chip_data_in[i]), .level(tone_data_s[i]));
		end
	endgenerate

	assign rst = sys_rst | slot_reset_s;

	assign req.addr      = slot_addr;
	assign req.sel_flash = sel_flash_s & ~sel_regs_s;
	assign req.sel_regs  = sel_regs_s & ~sel_flash_s;
	assign req.wr        = wr_s;
	assign req.rd        = rd_s;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wr_d_r <= 1'b0;
			rd_d_r <= 1'b0;
		end
		else
		begin
			wr_d_r <= req.wr;
			rd_d_r <= req.rd;
		end
	end

	assign wr_rise = req.wr & ~wr_d_r;
	assign rd_rise = req.rd & ~rd_d_r;

	// decode shared by the flash strobes, register writes and interrupt clear
	assign flash_wr  = req.sel_flash & req.wr & ~req.rd;
	assign flash_rd  = req.sel_flash & req.rd & ~req.wr;
	assign hit_int   = req.sel_regs & reg_hit(req.addr, slot_glue_pkg::REG_INT);
	assign hit_audio = req.sel_regs & reg_hit(req.addr, slot_glue_pkg::REG_AUDIO);
	assign hit_tone  = req.sel_regs & reg_hit(req.addr, slot_glue_pkg::REG_TONE);
	assign audio_wr  = wr_rise & hit_audio;
	assign tone_wr   = wr_rise & hit_tone;

	// flash pass-through; address is stable while strobes settle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			flash_addr     <= '0;
			flash_data_out <= '0;
		end
		else if (req.sel_flash)
		begin
			flash_addr <= req.addr;
			if (flash_wr)
				flash_data_out <= slot_data_in;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			flash_oe      <= 1'b0;
			flash_we      <= 1'b0;
			flash_data_oe <= 1'b0;
		end
		else
		begin
			flash_oe      <= flash_rd;
			flash_we      <= flash_wr;
			flash_data_oe <= flash_wr;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flash_reset <= 1'b1;
		else
			flash_reset <= slot_reset_s;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			flash_rd_r <= '0;
		else if (flash_oe)
			flash_rd_r <= flash_data_in;
	end

	// interrupt sources and clear on read
	always_comb
	begin
		int_src                             = '0;
		int_src[slot_glue_pkg::INT_BIT_TONE] = tone_int_s;
		int_src[slot_glue_pkg::INT_BIT_EXT]  = ext_int_s;
	end

	assign int_clear_on_read = rd_rise & hit_int;

	int_latch u_int (
		.clk              (clk),
		.sys_rst          (rst),
		.src              (int_src),
		.int_clear_on_read(int_clear_on_read),
		.host_low_battery (host_low_battery),
		.int_bits         (int_bits),
		.slot_irq         (slot_irq)
	);

	// audio register
	assign audio_reg_bus = slot_data_in[slot_glue_pkg::AUDIO_W-1:0];

	always_ff @(posedge clk)
	begin
		if (rst)
			audio_r <= slot_glue_pkg::AUDIO_RST;
		else if (audio_wr)
			audio_r <= audio_reg_bus;
	end

	assign audio_shutdown = audio_r[slot_glue_pkg::AUD_BIT_SHUTDOWN];
	assign audio_mute     = audio_r[slot_glue_pkg::AUD_BIT_MUTE];
	assign audio_mode     = audio_r[slot_glue_pkg::AUD_BIT_MODE];

	// tone transceiver register
	always_ff @(posedge clk)
	begin
		if (rst)
			tone_write_reg <= slot_glue_pkg::TONE_RST;
		else if (tone_wr)
			tone_write_reg <= slot_data_in[slot_glue_pkg::TONE_W-1:0];
	end

	assign tone_ctl = tone_write_reg;

	assign tone_chip_read_mode  = tone_ctl.read_mode;
	assign tone_chip_select     = tone_ctl.select;
	assign tone_chip_write_mode = tone_ctl.write_mode;
	assign tone_chip_reg_select = tone_ctl.reg_select;
	assign tone_chip_data_out   = tone_ctl.data;
	assign tone_chip_data_oe    = tone_ctl.write_mode & ~tone_ctl.read_mode;
	assign tone_rd_en           = tone_ctl.read_mode & tone_ctl.select;

	always_ff @(posedge clk)
	begin
		if (rst)
			tone_rd_r <= '0;
		else if (tone_rd_en)
			tone_rd_r <= tone_data_s;
	end

	// register read mux
	always_comb
	begin
		reg_rd_nxt = '0;
		case (req.addr[1:0])
			slot_glue_pkg::REG_INT:
				reg_rd_nxt[slot_glue_pkg::INT_W-1:0] = int_bits;
			slot_glue_pkg::REG_AUDIO:
				reg_rd_nxt[slot_glue_pkg::AUDIO_W-1:0] = audio_r;
			slot_glue_pkg::REG_TONE:
				reg_rd_nxt = {8'h00, tone_write_reg[7:4], tone_rd_r};
			default:
				reg_rd_nxt = '0;
		endcase
	end

	// slot data output, held through the strobe
	always_ff @(posedge clk)
	begin
		if (rst)
			slot_data_out <= '0;
		else if (req.sel_regs & rd_rise)
			slot_data_out <= reg_rd_nxt;
		else if (req.sel_flash & req.rd)
			slot_data_out <= flash_rd_r;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			slot_data_oe <= 1'b0;
		else
			slot_data_oe <= req.rd & ~req.wr & (req.sel_flash | req.sel_regs);
	end
endmodule : slot_glue

// >>> inc/slot_glue_pkg.sv
/*
 * shared constants and carriers for the expansion-slot glue logic.
 * assumes one 125 MHz clock and a synchronous active-high reset.
 */
package slot_glue_pkg;
	localparam int ADDR_W    = 24;
	localparam int DATA_W    = 16;
	localparam int INT_W     = 8;
	localparam int AUDIO_W   = 12;
	localparam int TONE_W    = 8;
	localparam int TONE_D_W  = 4;
	localparam int SYNC_W    = 3;

	// register-space word index, low address bits
	localparam logic [1:0] REG_INT   = 2'h0;
	localparam logic [1:0] REG_AUDIO = 2'h1;
	localparam logic [1:0] REG_TONE  = 2'h2;

	// interrupt bit positions
	localparam int INT_BIT_TONE = 0;
	localparam int INT_BIT_EXT  = 1;

	// audio field positions
	localparam int AUD_BIT_SHUTDOWN = 0;
	localparam int AUD_BIT_MUTE     = 1;
	localparam int AUD_BIT_MODE     = 2;

	// tone write register field positions
	localparam int TONE_BIT_READ_MODE  = 7;
	localparam int TONE_BIT_SELECT     = 6;
	localparam int TONE_BIT_WRITE_MODE = 5;
	localparam int TONE_BIT_REG_SELECT = 4;

	// reset values
	localparam logic [AUDIO_W-1:0]  AUDIO_RST = 12'h001;
	localparam logic [TONE_W-1:0]   TONE_RST  = 8'h00;
	localparam logic [INT_W-1:0]    INT_RST   = 8'h00;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              sel_flash;
		logic              sel_regs;
		logic              wr;
		logic              rd;
	} slot_req_t;

	typedef struct packed {
		logic                read_mode;
		logic                select;
		logic                write_mode;
		logic                reg_select;
		logic [TONE_D_W-1:0] data;
	} tone_ctl_t;
endpackage : slot_glue_pkg

// >>> hdl/pin_sync.sv
/*
 * three-stage input synchroniser with agreement filter.
 * assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,     // system clock
	input  wire logic sys_rst, // synchronous reset
	input  wire logic pin_in,  // raw pin
	output logic      level    // filtered level
);
	logic [2:0] stage_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			stage_r <= {3{RST_VAL}};
		else
			stage_r <= {stage_r[1:0], pin_in};
	end

	// change counts once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			level <= RST_VAL;
		else if (stage_r[1] == stage_r[2])
			level <= stage_r[2];
	end
endmodule : pin_sync

// >>> hdl/int_latch.sv
/*
 * sticky interrupt register with clear on read.
 * assumes sources are already synchronised to clk.
 */
`timescale 1ns/1ps
module int_latch (
	input  wire logic                            clk,        // system clock
	input  wire logic                            sys_rst,    // synchronous reset
	input  wire logic [slot_glue_pkg::INT_W-1:0] src,        // source levels
	input  wire logic                            int_clear_on_read, // clear pulse
	input  wire logic                            host_low_battery,  // masks irq
	output logic      [slot_glue_pkg::INT_W-1:0] int_bits,   // latched bits
	output logic                                 slot_irq    // to host
);
	logic [slot_glue_pkg::INT_W-1:0] src_d_r;
	logic [slot_glue_pkg::INT_W-1:0] rise;

	assign rise = src & ~src_d_r;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			src_d_r <= slot_glue_pkg::INT_RST;
		else
			src_d_r <= src;
	end

	// new event wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			int_bits <= slot_glue_pkg::INT_RST;
		else if (int_clear_on_read)
			int_bits <= rise;
		else
			int_bits <= int_bits | rise;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			slot_irq <= 1'b0;
		else
			slot_irq <= (|int_bits) & ~host_low_battery & ~int_clear_on_read;
	end
endmodule : int_latch

// >>> tb/slot_glue_chk.sv
/*
 * port-level assertions for the slot glue block.
 * assumes it is bound to slot_glue and sees only its ports.
 */
`timescale 1ns/1ps
module slot_glue_chk (
	input wire logic                              clk,              // system clock
	input wire logic                              sys_rst,          // sync reset
	input wire logic [slot_glue_pkg::ADDR_W-1:0]  slot_addr,        // slot address
	input wire logic                              slot_sel_flash,   // flash select
	input wire logic                              slot_sel_regs,    // register select
	input wire logic                              slot_wr,          // write strobe
	input wire logic                              slot_rd,          // read strobe
	input wire logic                              slot_irq,         // interrupt out
	input wire logic                              host_low_battery, // low battery
	input wire logic                              ext_int,          // spare source
	input wire logic                              tone_received_int, // tone source
	input wire logic                              slot_data_oe,     // slot drive
	input wire logic [slot_glue_pkg::ADDR_W-1:0]  flash_addr,       // flash address
	input wire logic                              flash_oe,         // flash read
	input wire logic                              flash_we,         // flash write
	input wire logic                              flash_reset,      // flash reset
	input wire logic                              audio_shutdown    // audio off
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence one_sel;
		slot_sel_flash != slot_sel_regs;
	endsequence
	sequence rd_start;
		$rose(slot_rd) && !slot_wr ##0 one_sel;
	endsequence
	sequence int_read;
		rd_start ##0 slot_sel_regs && slot_addr[1:0] == 2'h0
			&& !tone_received_int && !ext_int;
	endsequence
	a_reset_values: assert property ($fell(sys_rst) |-> audio_shutdown && flash_reset)
		else $error("reset values wrong");
	a_lowbat_mask: assert property (host_low_battery [*2] |-> !slot_irq)
		else $error("irq raised under low battery");
	a_oe_we_excl: assert property (!(flash_oe && flash_we))
		else $error("flash read and write together");
	a_we_cause: assert property ($rose(flash_we) |-> $past(slot_wr, 2) && $past(slot_sel_flash, 2))
		else $error("flash write without host write");
	a_oe_cause: assert property ($rose(flash_oe) |-> $past(slot_rd, 2) && $past(slot_sel_flash, 2))
		else $error("flash read without host read");
	a_we_answer: assert property ($rose(slot_wr) && !slot_rd && slot_sel_flash && !slot_sel_regs
		|-> ##[2:8] flash_we)
		else $error("flash write missing");
	a_we_addr: assert property (flash_we |-> flash_addr == slot_addr)
		else $error("flash address differs");
	a_rd_answer: assert property (rd_start |-> ##[2:8] slot_data_oe)
		else $error("read data not driven");
	a_oe_needs_rd: assert property ($rose(slot_data_oe) |-> $past(slot_rd, 2))
		else $error("slot driven without read");
	a_int_clear: assert property (int_read |-> ##[2:8] !slot_irq)
		else $error("interrupt not cleared by read");
endmodule : slot_glue_chk

// >>> tb/far_side_model.sv
/*
 * flash memory and tone transceiver seen from the glue's pins.
 * assumes the bench calls tone_event and sets tone_digit.
 */
`timescale 1ns/1ps
module far_side_model (
	input wire logic        clk,               // system clock
	input wire logic [23:0] flash_addr,        // flash address
	input wire logic [15:0] flash_data_out,    // write data
	input wire logic        flash_oe,          // read enable
	input wire logic        flash_we,          // write enable
	output logic     [15:0] flash_data_in,     // read data
	input wire logic        tone_chip_read_mode, // read mode
	input wire logic        tone_chip_select,  // chip select
	output logic     [3:0]  tone_chip_data_in, // tone bus
	output logic            tone_received_int  // tone irq
);
	logic [15:0] mem [logic [23:0]];
	logic [15:0] last_r = 16'h0000;
	logic [3:0]  tone_digit = 4'h0;
	logic        we_d = 1'b0;
	int          wr_cnt = 0;
	initial tone_received_int = 1'b0;
	always @(posedge clk)
	begin
		we_d <= flash_we;
		if (flash_we)
			mem[flash_addr] = flash_data_out;
		if (flash_we && !we_d)
			wr_cnt <= wr_cnt + 1;
		if (flash_oe)
			last_r <= flash_data_in;
	end
	// released bus shows inverse of last value
	always_comb flash_data_in = !flash_oe ? ~last_r :
		(mem.exists(flash_addr) ? mem[flash_addr] : 16'h0000);
	always_comb tone_chip_data_in = (tone_chip_read_mode && tone_chip_select) ?
		tone_digit : ~tone_digit;
	task tone_event();
		@(negedge clk);
		tone_received_int = 1'b1;
		repeat (6) @(negedge clk);
		tone_received_int = 1'b0;
	endtask : tone_event
endmodule : far_side_model

// >>> tb/testbench.sv
/*
 * self-checking bench for the slot glue: host accesses by task.
 * assumes a 125 MHz clock and strobes held well over five cycles.
 */
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0, sys_rst = 1'b1, slot_reset = 1'b0, slot_wr = 1'b0, slot_rd = 1'b0;
	logic slot_sel_flash = 1'b0, slot_sel_regs = 1'b0, host_low_battery = 1'b0;
	logic ext_int = 1'b0, slot_irq, slot_data_oe, flash_data_oe, flash_oe, flash_we;
	logic flash_reset, audio_shutdown, audio_mute, audio_mode, tone_chip_data_oe;
	logic tone_chip_write_mode, tone_chip_read_mode, tone_chip_reg_select;
	logic tone_chip_select, tone_received_int;
	logic [23:0] slot_addr = 24'h000000, flash_addr;
	logic [15:0] slot_data_in = 16'h0000, slot_data_out, flash_data_in, flash_data_out, q;
	logic [3:0]  tone_chip_data_in, tone_chip_data_out;
	int          miscompares = 0, n_tests = 0, cyc = 0, wc;
	initial forever #4 clk = ~clk;
	slot_glue u_slot_glue (.clk, .sys_rst, .slot_reset, .slot_addr, .slot_data_in,
		.slot_data_out, .slot_data_oe, .slot_sel_flash, .slot_sel_regs, .slot_wr,
		.slot_rd, .slot_irq, .host_low_battery, .flash_addr, .flash_data_in,
		.flash_data_out, .flash_data_oe, .flash_oe, .flash_we, .flash_reset, .ext_int,
		.audio_shutdown, .audio_mute, .audio_mode, .tone_chip_data_in,
		.tone_chip_data_out, .tone_chip_data_oe, .tone_chip_write_mode,
		.tone_chip_read_mode, .tone_chip_reg_select, .tone_chip_select,
		.tone_received_int);
	far_side_model u_far_side_model (.clk, .flash_addr, .flash_data_out, .flash_oe,
		.flash_we, .flash_data_in, .tone_chip_read_mode, .tone_chip_select,
		.tone_chip_data_in, .tone_received_int);
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task acc(input logic fl, input logic w, input logic [23:0] a, input logic [15:0] d);
		@(negedge clk);
		slot_addr = a;
		slot_data_in = d;
		slot_sel_flash = fl;
		slot_sel_regs = !fl;
		slot_wr = w;
		slot_rd = !w;
		repeat (10) @(negedge clk);
		q = slot_data_out;
		check(16'({slot_data_oe, flash_we, flash_data_oe, flash_oe}),
			16'({!w, fl & w, fl & w, fl & !w}));
		slot_wr = 1'b0;
		slot_rd = 1'b0;
		// strobe falls first; select, address and data are held past it
		repeat (6) @(negedge clk);
		slot_sel_flash = 1'b0;
		slot_sel_regs = 1'b0;
		slot_data_in = ~d;
		repeat (6) @(negedge clk);
	endtask : acc
	task wrap_up();
		$display("comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			miscompares++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (12) @(negedge clk);
		check(16'({flash_reset, audio_shutdown, audio_mute}), 16'h0006);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		check(16'(slot_irq), 16'h0000);
		$display("test reset done");
		acc(1'b1, 1'b1, 24'hffffff, 16'hbeef);
		acc(1'b1, 1'b1, 24'h000000, 16'h1234);
		check(u_far_side_model.mem[24'hffffff], 16'hbeef);
		check(16'(u_far_side_model.wr_cnt), 16'h0002);
		acc(1'b1, 1'b0, 24'hffffff, 16'h0000);
		check(q, 16'hbeef);
		acc(1'b1, 1'b0, 24'h000000, 16'h0000);
		check(q, 16'h1234);
		$display("test flash done");
		wc = u_far_side_model.wr_cnt;
		acc(1'b0, 1'b1, 24'h000001, 16'h0002);
		check(16'({audio_mode, audio_mute, audio_shutdown}), 16'h0002);
		acc(1'b0, 1'b1, 24'h000001, 16'h0005);
		check(16'({audio_mode, audio_mute, audio_shutdown}), 16'h0005);
		check(16'(u_far_side_model.wr_cnt - wc), 16'h0000);
		$display("test audio done");
		u_far_side_model.tone_digit = 4'ha;
		acc(1'b0, 1'b1, 24'h000002, 16'h00d0);
		check(16'({tone_chip_data_oe, tone_chip_read_mode, tone_chip_select,
			tone_chip_write_mode, tone_chip_reg_select}), 16'h000d);
		acc(1'b0, 1'b0, 24'h000002, 16'h0000);
		check(q, 16'h00da);
		acc(1'b0, 1'b1, 24'h000002, 16'h006c);
		check(16'({tone_chip_data_oe, tone_chip_read_mode, tone_chip_select,
			tone_chip_write_mode, tone_chip_reg_select, tone_chip_data_out}),
			16'h016c);
		acc(1'b0, 1'b0, 24'h000003, 16'h0000);
		check(q, 16'h0000);
		$display("test tone done");
		u_far_side_model.tone_event();
		repeat (8) @(negedge clk);
		check(16'(slot_irq), 16'h0001);
		ext_int = 1'b1;
		repeat (6) @(negedge clk);
		ext_int = 1'b0;
		repeat (6) @(negedge clk);
		acc(1'b0, 1'b0, 24'h000000, 16'h0000);
		check(q, 16'h0003);
		check(16'(slot_irq), 16'h0000);
		acc(1'b0, 1'b0, 24'h000000, 16'h0000);
		check(q, 16'h0000);
		host_low_battery = 1'b1;
		u_far_side_model.tone_event();
		repeat (8) @(negedge clk);
		check(16'(slot_irq), 16'h0000);
		acc(1'b0, 1'b0, 24'h000000, 16'h0000);
		host_low_battery = 1'b0;
		repeat (4) @(negedge clk);
		check(16'(slot_irq), 16'h0000);
		$display("test interrupt done");
		slot_reset = 1'b1;
		repeat (8) @(negedge clk);
		check(16'({flash_reset, audio_shutdown, audio_mute, audio_mode}), 16'h000c);
		slot_reset = 1'b0;
		repeat (8) @(negedge clk);
		$display("test slot reset done");
		wrap_up();
	end
endmodule : testbench
bind slot_glue slot_glue_chk u_slot_glue_chk (.clk, .sys_rst, .slot_addr, .slot_sel_flash,
	.slot_sel_regs, .slot_wr, .slot_rd, .slot_irq, .host_low_battery, .ext_int,
	.tone_received_int, .slot_data_oe, .flash_addr, .flash_oe, .flash_we, .flash_reset,
	.audio_shutdown);
